// ---- lsp_map.svh ----
/*
 * Register offsets, reset values and timing counts of the link scheduler.
 * Assumes a 100 MHz system clock and a byte-addressed register port.
 */
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LSP_OFS_CTRL 8'h00
`define LSP_OFS_SKIP_START 8'h04
`define LSP_OFS_SKIP_LEN 8'h08
`define LSP_OFS_TOK_HOLD 8'h0c
`define LSP_OFS_NODE_CNT 8'h10
`define LSP_OFS_RESP_WAIT 8'h14
`define LSP_OFS_NEW_WAIT 8'h18
`define LSP_OFS_SA_ADDR 8'h1c
`define LSP_OFS_STATUS 8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LSP_CTRL_EN_BIT 0
`define LSP_CTRL_SA_GO_BIT 1
`define LSP_ST_DONE_BIT 8
`define LSP_ST_STALL_BIT 9
`define LSP_ST_BUSY_BIT 10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LSP_RST_SKIP_START 8'h25
`define LSP_RST_SKIP_LEN 8'hba
`define LSP_RST_TOK_HOLD 16'h0020
`define LSP_RST_RESP_WAIT 24'h075300
`define LSP_RST_NEW_WAIT 24'h15f900

// ----------------------------------------------------------------------
// Address range and timing
// ----------------------------------------------------------------------
`define LSP_ADDR_FIRST 8'h10
`define LSP_ADDR_LAST 8'hff
`define LSP_CLK_MHZ 100
`define LSP_TICK_NS 31250
`define LSP_TICK_CYCLES ((`LSP_TICK_NS * `LSP_CLK_MHZ) / 1000)

`endif

// ---- lsp_pkg.sv ----
/*
 * Types shared by the link scheduler files.
 * Assumes lsp_map.svh supplies every number.
 */
package lsp_pkg;
  typedef enum logic [2:0] {
    LSP_SA_IDLE,
    LSP_SA_WAIT_ID,
    LSP_SA_WAIT_NEW,
    LSP_SA_WAIT_PR
  } lsp_sa_e;
  typedef logic [7:0] lsp_node_t;
endpackage

// ---- lsp_delay_timer.sv ----
/*
 * Down-counting delay timer in scheduler ticks.
 * Assumes tick is a one-cycle pulse from the same clock.
 */
`timescale 1ns/1ps
module lsp_delay_timer import lsp_pkg::*; #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic busy_q,
  output logic expired_q
);
  logic [W-1:0] cnt_q, cnt_d;
  logic busy_d, expired_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    expired_d = 1'b0;
    if (load) begin
      cnt_d = load_val;
      busy_d = 1'b1;
    end else if (busy_q) begin
      // A zero load expires at once rather than wrapping
      if (cnt_q == '0 || (tick && cnt_q == W'(1))) begin
        busy_d = 1'b0;
        expired_d = 1'b1;
        cnt_d = '0;
      end else if (tick) begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      expired_q <= expired_d;
    end
  end
endmodule

// ---- lsp_sched.sv ----
/*
 * Link scheduler: probe walker with skip region, set-address timing.
 * Assumes link frame indications arrive as one-cycle pulses on clk.
 */
// The register offsets and the plain strobed port were left to the implementer.
// Overview of operation
// - Delay timers count 1/32 millisecond ticks
// - Active scheduler probes every listed address
// - Probe spacing from node count, token hold
// - Skip region start through start plus length
// - After last address wrap to first
// - Probe range is addresses 16 to 255
// - Unprobed node never joins the link
// - Query, identify reply, then set address
// - Reply wait bounded; late reply stalls sequence
// - Identify new address after delay and probe reply
// - Moved node rejoins after new address probed
`timescale 1ns/1ps
`include "lsp_map.svh"
module lsp_sched import lsp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // Link receive indications
  input wire logic ident_rx,
  input wire logic [7:0] ident_src,
  input wire logic probe_resp_rx,
  input wire logic [7:0] probe_resp_src,
  // Link transmit requests
  output logic probe_tx_q,
  output logic [7:0] probe_addr_q,
  output logic query_tx_q,
  output logic set_addr_tx_q,
  output logic ident_tx_q,
  output logic [7:0] frame_dst_q
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic in_skip(lsp_node_t a, lsp_node_t s, lsp_node_t n);
    logic [8:0] e;
    e = {1'b0, s} + {1'b0, n};
    return (n != 8'h00) && (a >= s) && ({1'b0, a} <= e);
  endfunction

  function automatic lsp_node_t next_addr(lsp_node_t a, lsp_node_t s,
                                          lsp_node_t n);
    logic [8:0] c;
    c = (a >= `LSP_ADDR_LAST) ? {1'b0, `LSP_ADDR_FIRST} : {1'b0, a} + 9'h001;
    if (in_skip(c[7:0], s, n))
      c = {1'b0, s} + {1'b0, n} + 9'h001;
    if (c > {1'b0, `LSP_ADDR_LAST} || c < {1'b0, `LSP_ADDR_FIRST})
      c = {1'b0, `LSP_ADDR_FIRST};
    return c[7:0];
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic en_q, en_d;
  lsp_node_t skip_start_q, skip_start_d, skip_len_q, skip_len_d;
  logic [15:0] tok_hold_q, tok_hold_d;
  lsp_node_t node_cnt_q, node_cnt_d;
  logic [23:0] resp_wait_q, resp_wait_d, new_wait_q, new_wait_d;
  lsp_node_t sa_cur_q, sa_cur_d, sa_new_q, sa_new_d;
  logic [31:0] rdata_d;
  logic sa_go;
  logic done_q, done_d, stall_q, stall_d;
  lsp_sa_e sa_q, sa_d;
  lsp_node_t paddr_q, paddr_d;

  always_comb begin
    en_d = en_q;
    skip_start_d = skip_start_q;
    skip_len_d = skip_len_q;
    tok_hold_d = tok_hold_q;
    node_cnt_d = node_cnt_q;
    resp_wait_d = resp_wait_q;
    new_wait_d = new_wait_q;
    sa_cur_d = sa_cur_q;
    sa_new_d = sa_new_q;
    sa_go = 1'b0;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `LSP_OFS_CTRL: begin
          en_d = reg_wdata[`LSP_CTRL_EN_BIT];
          sa_go = reg_wdata[`LSP_CTRL_SA_GO_BIT];
        end
        `LSP_OFS_SKIP_START: skip_start_d = reg_wdata[7:0];
        `LSP_OFS_SKIP_LEN: skip_len_d = reg_wdata[7:0];
        `LSP_OFS_TOK_HOLD: tok_hold_d = reg_wdata[15:0];
        `LSP_OFS_NODE_CNT: node_cnt_d = reg_wdata[7:0];
        `LSP_OFS_RESP_WAIT: resp_wait_d = reg_wdata[23:0];
        `LSP_OFS_NEW_WAIT: new_wait_d = reg_wdata[23:0];
        `LSP_OFS_SA_ADDR: begin
          // Addresses held while a sequence runs
          if (sa_q == LSP_SA_IDLE) begin
            sa_cur_d = reg_wdata[7:0];
            sa_new_d = reg_wdata[15:8];
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `LSP_OFS_CTRL: rdata_d = {31'h0, en_q};
        `LSP_OFS_SKIP_START: rdata_d = {24'h0, skip_start_q};
        `LSP_OFS_SKIP_LEN: rdata_d = {24'h0, skip_len_q};
        `LSP_OFS_TOK_HOLD: rdata_d = {16'h0, tok_hold_q};
        `LSP_OFS_NODE_CNT: rdata_d = {24'h0, node_cnt_q};
        `LSP_OFS_RESP_WAIT: rdata_d = {8'h0, resp_wait_q};
        `LSP_OFS_NEW_WAIT: rdata_d = {8'h0, new_wait_q};
        `LSP_OFS_SA_ADDR: rdata_d = {16'h0, sa_new_q, sa_cur_q};
        `LSP_OFS_STATUS: begin
          rdata_d[7:0] = paddr_q;
          rdata_d[`LSP_ST_DONE_BIT] = done_q;
          rdata_d[`LSP_ST_STALL_BIT] = stall_q;
          rdata_d[`LSP_ST_BUSY_BIT] = (sa_q != LSP_SA_IDLE);
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 1'b0;
      skip_start_q <= `LSP_RST_SKIP_START;
      skip_len_q <= `LSP_RST_SKIP_LEN;
      tok_hold_q <= `LSP_RST_TOK_HOLD;
      node_cnt_q <= 8'h00;
      resp_wait_q <= `LSP_RST_RESP_WAIT;
      new_wait_q <= `LSP_RST_NEW_WAIT;
      sa_cur_q <= 8'h00;
      sa_new_q <= 8'h00;
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      en_q <= en_d;
      skip_start_q <= skip_start_d;
      skip_len_q <= skip_len_d;
      tok_hold_q <= tok_hold_d;
      node_cnt_q <= node_cnt_d;
      resp_wait_q <= resp_wait_d;
      new_wait_q <= new_wait_d;
      sa_cur_q <= sa_cur_d;
      sa_new_q <= sa_new_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------
  // Tick generator
  // --------------------------------------------------------------------
  localparam int TICK_N = `LSP_TICK_CYCLES;
  logic [11:0] tick_cnt_q, tick_cnt_d;
  logic tick;

  always_comb begin
    tick = (tick_cnt_q == 12'(TICK_N - 1));
    tick_cnt_d = tick ? 12'h000 : tick_cnt_q + 12'h001;
  end

  // --------------------------------------------------------------------
  // Probe walker
  // --------------------------------------------------------------------
  logic p_busy, p_load;
  logic [23:0] gap;
  logic probe_tx_d;
  logic [7:0] probe_addr_d;

  always_comb begin
    // More devices on the link stretch the gap between probes
    gap = 24'(tok_hold_q) * 24'({1'b0, node_cnt_q} + 9'h001);
    paddr_d = paddr_q;
    p_load = 1'b0;
    probe_tx_d = 1'b0;
    probe_addr_d = probe_addr_q;
    if (en_q && !p_busy && !probe_tx_q) begin
      // Skipped nodes are stepped over and stay off the link
      if (!in_skip(paddr_q, skip_start_q, skip_len_q)) begin
        probe_tx_d = 1'b1;
        probe_addr_d = paddr_q;
        p_load = 1'b1;
      end
      paddr_d = next_addr(paddr_q, skip_start_q, skip_len_q);
    end
  end

  lsp_delay_timer #(.W(24)) u_gap (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .load(p_load),
    .load_val(gap),
    .busy_q(p_busy),
    .expired_q()
  );

  // --------------------------------------------------------------------
  // Set-address sequencer
  // --------------------------------------------------------------------
  logic s_busy, s_exp, s_load;
  logic [23:0] s_val;
  logic query_tx_d, set_tx_d, ident_tx_d, pr_seen_q, pr_seen_d;
  logic [7:0] dst_d;
  logic pr_new;

  always_comb begin
    sa_d = sa_q;
    s_load = 1'b0;
    s_val = resp_wait_q;
    query_tx_d = 1'b0;
    set_tx_d = 1'b0;
    ident_tx_d = 1'b0;
    dst_d = frame_dst_q;
    done_d = done_q;
    stall_d = stall_q;
    pr_seen_d = pr_seen_q;
    pr_new = probe_resp_rx && (probe_resp_src == sa_new_q);
    case (sa_q)
      LSP_SA_IDLE: begin
        if (sa_go) begin
          query_tx_d = 1'b1;
          dst_d = sa_cur_q;
          s_load = 1'b1;
          s_val = resp_wait_q;
          done_d = 1'b0;
          stall_d = 1'b0;
          sa_d = LSP_SA_WAIT_ID;
        end
      end
      LSP_SA_WAIT_ID: begin
        if (ident_rx && ident_src == sa_cur_q) begin
          set_tx_d = 1'b1;
          dst_d = sa_cur_q;
          s_load = 1'b1;
          s_val = new_wait_q;
          pr_seen_d = 1'b0;
          sa_d = LSP_SA_WAIT_NEW;
        end else if (s_exp) begin
          // Late replies are not honoured; software restarts
          stall_d = 1'b1;
          sa_d = LSP_SA_IDLE;
        end
      end
      LSP_SA_WAIT_NEW: begin
        if (pr_new)
          pr_seen_d = 1'b1;
        if (s_exp)
          sa_d = LSP_SA_WAIT_PR;
      end
      LSP_SA_WAIT_PR: begin
        if (pr_seen_q || pr_new) begin
          ident_tx_d = 1'b1;
          dst_d = sa_new_q;
          done_d = 1'b1;
          sa_d = LSP_SA_IDLE;
        end
      end
      default: sa_d = LSP_SA_IDLE;
    endcase
  end

  lsp_delay_timer #(.W(24)) u_sa (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick),
    .load(s_load),
    .load_val(s_val),
    .busy_q(s_busy),
    .expired_q(s_exp)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 12'h000;
      paddr_q <= `LSP_ADDR_FIRST;
      probe_tx_q <= 1'b0;
      probe_addr_q <= 8'h00;
      sa_q <= LSP_SA_IDLE;
      query_tx_q <= 1'b0;
      set_addr_tx_q <= 1'b0;
      ident_tx_q <= 1'b0;
      frame_dst_q <= 8'h00;
      done_q <= 1'b0;
      stall_q <= 1'b0;
      pr_seen_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      paddr_q <= paddr_d;
      probe_tx_q <= probe_tx_d;
      probe_addr_q <= probe_addr_d;
      sa_q <= sa_d;
      query_tx_q <= query_tx_d;
      set_addr_tx_q <= set_tx_d;
      ident_tx_q <= ident_tx_d;
      frame_dst_q <= dst_d;
      done_q <= done_d;
      stall_q <= stall_d;
      pr_seen_q <= pr_seen_d;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_query;
    query_tx_q;
  endsequence
  sequence s_identified;
    $past(ident_rx) && $past(ident_src) == frame_dst_q;
  endsequence

  chk_tick_period: assert property (
    tick_cnt_q == 12'(TICK_N - 1) |=> tick_cnt_q == 12'h000)
    else $error("tick period wrong");
  chk_probe_enable: assert property (
    probe_tx_q |-> $past(en_q))
    else $error("probe while disabled");
  chk_probe_gap: assert property (
    probe_tx_q |-> p_busy ##1 !probe_tx_q)
    else $error("probe gap not started");
  chk_probe_skip: assert property (
    probe_tx_q |-> !in_skip(probe_addr_q, skip_start_q, skip_len_q)
                   || $changed(skip_start_q) || $changed(skip_len_q))
    else $error("probe in skipped region");
  chk_probe_wrap: assert property (
    probe_tx_q && probe_addr_q == `LSP_ADDR_LAST |-> paddr_q ==
      `LSP_ADDR_FIRST || in_skip(`LSP_ADDR_FIRST, skip_start_q, skip_len_q))
    else $error("no wrap after last address");
  chk_probe_range: assert property (
    probe_tx_q |-> probe_addr_q >= `LSP_ADDR_FIRST)
    else $error("probe below range");
  chk_full_range: assert property (
    probe_tx_q && skip_len_q == 8'h00 && probe_addr_q != `LSP_ADDR_LAST
      |-> paddr_q == probe_addr_q + 8'h01)
    else $error("address skipped with zero length");
  chk_query_order: assert property (
    set_addr_tx_q |-> s_identified ##0 $past(sa_q) == LSP_SA_WAIT_ID)
    else $error("set address without identify");
  chk_query_wait: assert property (
    s_query |-> sa_q == LSP_SA_WAIT_ID && s_busy)
    else $error("reply wait not started");
  chk_reply_stall: assert property (
    sa_q == LSP_SA_WAIT_ID && s_exp && !ident_rx |=> stall_q
      && sa_q == LSP_SA_IDLE)
    else $error("expired wait did not stall");
  chk_ident_after: assert property (
    ident_tx_q |-> $past(sa_q) == LSP_SA_WAIT_PR
      && ($past(pr_seen_q) || $past(pr_new)))
    else $error("identify before probe reply");
endmodule

// ---- lsp_field_dev.sv ----
/*
 * Behavioural field device on the shared link, facing the scheduler.
 * Assumes frame indications are one-cycle pulses on the scheduler clock.
 */
`timescale 1ns/1ps
module lsp_field_dev import lsp_pkg::*; #(
  parameter lsp_node_t HOME = 8'h20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bench setup
  input wire lsp_node_t moved_addr,
  input wire logic [15:0] reply_dly,
  // Frames from the scheduler
  input wire logic probe_tx_q,
  input wire lsp_node_t probe_addr_q,
  input wire logic query_tx_q,
  input wire logic set_addr_tx_q,
  input wire lsp_node_t frame_dst_q,
  // Frames back to the scheduler
  output logic ident_rx,
  output lsp_node_t ident_src,
  output logic probe_resp_rx,
  output lsp_node_t probe_resp_src
);
  lsp_node_t cur_q;
  logic [15:0] id_cnt_q;
  logic [1:0] pr_cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= HOME;
      id_cnt_q <= 16'h0;
      pr_cnt_q <= 2'h0;
      ident_rx <= 1'b0;
      ident_src <= 8'h0;
      probe_resp_rx <= 1'b0;
      probe_resp_src <= 8'h0;
    end else begin
      ident_rx <= 1'b0;
      probe_resp_rx <= 1'b0;
      // Source lines toggle between replies so stale values never hold steady; a stale source matches again every other cycle
      ident_src <= ~ident_src;
      probe_resp_src <= ~probe_resp_src;
      if (query_tx_q && frame_dst_q == cur_q) begin
        id_cnt_q <= reply_dly;
      end else if (id_cnt_q == 16'h1) begin
        id_cnt_q <= 16'h0;
        ident_rx <= 1'b1;
        ident_src <= cur_q;
      end else if (id_cnt_q != 16'h0) begin
        id_cnt_q <= id_cnt_q - 16'h1;
      end
      // Speaks only when probed at the address it holds now
      if (probe_tx_q && probe_addr_q == cur_q) begin
        pr_cnt_q <= 2'h2;
      end else if (pr_cnt_q == 2'h1) begin
        pr_cnt_q <= 2'h0;
        probe_resp_rx <= 1'b1;
        probe_resp_src <= cur_q;
      end else if (pr_cnt_q != 2'h0) begin
        pr_cnt_q <= pr_cnt_q - 2'h1;
      end
      if (set_addr_tx_q && frame_dst_q == cur_q) begin
        cur_q <= moved_addr;
      end
    end
  end
endmodule

// ---- link_scheduler_probe_and_set_address_tb.sv ----
/*
 * Self-checking bench for the link scheduler with one field device.
 * Assumes lsp_map.svh offsets and a 100 MHz clock.
 */
`timescale 1ns/1ps
`include "lsp_map.svh"
`define CHK_EQ(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module link_scheduler_probe_and_set_address_tb import lsp_pkg::*;;
  // ----------------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } lsp_row_s;
  lsp_row_s rows [15] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h25},
    '{1'b0, 8'h08, 32'h0, 32'hba}, '{1'b0, 8'h0c, 32'h0, 32'h20},
    '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h75300},
    '{1'b0, 8'h18, 32'h0, 32'h15f900}, '{1'b0, 8'h1c, 32'h0, 32'h0},
    '{1'b0, 8'h24, 32'h0, 32'h0}, '{1'b1, 8'h24, 32'h5, 32'h0},
    '{1'b1, 8'h0c, 32'hffffffff, 32'hffff}, '{1'b1, 8'h0c, 32'h0, 32'h0},
    '{1'b1, 8'h10, 32'hffffffff, 32'hff}, '{1'b1, 8'h10, 32'h0, 32'h0},
    '{1'b1, 8'h1c, 32'hffffffff, 32'hffff}};
  logic clk;
  logic arst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata_q;
  logic ident_rx, probe_resp_rx, probe_tx_q, query_tx_q;
  logic set_addr_tx_q, ident_tx_q;
  lsp_node_t ident_src, probe_resp_src, probe_addr_q, frame_dst_q;
  lsp_node_t dev_new, q_dst, id_dst;
  logic [15:0] reply_dly;
  logic [7:0] probes [$];
  logic [31:0] rdat;
  int n_fail = 0, tests_run = 0, cyc = 0, n_set = 0, n_idtx = 0;
  int t_idrx = 0, t_set = 0, t_pr = 0, t_idtx = 0;

  lsp_sched uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .ident_rx(ident_rx), .ident_src(ident_src),
    .probe_resp_rx(probe_resp_rx), .probe_resp_src(probe_resp_src),
    .probe_tx_q(probe_tx_q), .probe_addr_q(probe_addr_q),
    .query_tx_q(query_tx_q), .set_addr_tx_q(set_addr_tx_q),
    .ident_tx_q(ident_tx_q), .frame_dst_q(frame_dst_q));
  lsp_field_dev #(.HOME(8'h20)) dev (.clk(clk), .arst_n(arst_n),
    .moved_addr(dev_new), .reply_dly(reply_dly), .probe_tx_q(probe_tx_q),
    .probe_addr_q(probe_addr_q), .query_tx_q(query_tx_q),
    .set_addr_tx_q(set_addr_tx_q), .frame_dst_q(frame_dst_q),
    .ident_rx(ident_rx), .ident_src(ident_src),
    .probe_resp_rx(probe_resp_rx), .probe_resp_src(probe_resp_src));

  always #5 clk = ~clk;

  // Monitor; the cycle ceiling is well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (probe_tx_q === 1'b1) probes.push_back(probe_addr_q);
    if (query_tx_q === 1'b1) q_dst = frame_dst_q;
    if (ident_rx === 1'b1) t_idrx = cyc;
    if (set_addr_tx_q === 1'b1) begin
      n_set++;
      t_set = cyc;
    end
    // Only the first response after a set counts
    if (probe_resp_rx === 1'b1 && probe_resp_src === dev_new &&
        cyc > t_set && t_pr <= t_set)
      t_pr = cyc;
    if (ident_tx_q === 1'b1) begin
      n_idtx++;
      t_idtx = cyc;
      id_dst = frame_dst_q;
    end
    if (cyc == 70000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata_q;
  endtask

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  function automatic logic ok_addr(input logic [7:0] a, st, ln);
    return a >= 8'h10 &&
      !(ln != 8'h00 && int'(a) >= int'(st) && int'(a) <= st + ln);
  endfunction

  function automatic logic [7:0] nxt(input logic [7:0] a, st, ln);
    logic [7:0] b;
    b = a;
    for (int k = 0; k < 256; k++) begin
      b = (b == 8'hff) ? 8'h10 : b + 8'h1;
      if (ok_addr(b, st, ln)) break;
    end
    return b;
  endfunction

  task automatic walk_chk(input logic [7:0] st, ln, input int n);
    wr(`LSP_OFS_CTRL, 32'h0);
    wr(`LSP_OFS_SKIP_START, {24'h0, st});
    wr(`LSP_OFS_SKIP_LEN, {24'h0, ln});
    repeat (8) @(posedge clk);
    probes.delete();
    wr(`LSP_OFS_CTRL, 32'h1);
    for (int k = 0; k < 5000 && probes.size() < n; k++) @(posedge clk);
    `CHK_EQ(ok_addr(probes[0], st, ln), 1'b1)
    for (int k = 1; k < n; k++) begin
      `CHK_EQ(probes[k], nxt(probes[k-1], st, ln))
    end
    $display("probe walk done");
  endtask

  task automatic wait_probe(output int t);
    t = 0;
    for (int k = 0; k < 20000; k++) begin
      @(posedge clk);
      #1;
      if (probe_tx_q === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask

  task automatic gap_chk(input int th, input int nc);
    int ta, tb, e;
    wr(`LSP_OFS_TOK_HOLD, th);
    wr(`LSP_OFS_NODE_CNT, nc);
    // The first gap may still run on the old setting
    wait_probe(ta);
    wait_probe(ta);
    wait_probe(tb);
    e = th * (nc + 1) * 3125;
    `CHK_EQ(tb - ta >= e && tb - ta <= e + 4, 1'b1)
    $display("probe gap done");
  endtask

  task automatic sa_run(input logic [7:0] cur, nw, input logic [31:0] nwait,
                        input logic [15:0] dly, input logic ok);
    int n0, k0;
    logic [31:0] st;
    n0 = n_set;
    k0 = n_idtx;
    @(posedge clk);
    dev_new <= nw;
    reply_dly <= dly;
    wr(`LSP_OFS_NEW_WAIT, nwait);
    wr(`LSP_OFS_SA_ADDR, {16'h0, nw, cur});
    wr(`LSP_OFS_CTRL, 32'h3);
    repeat (4) @(posedge clk);
    `CHK_EQ(q_dst, cur)
    for (int k = 0; k < 9000 && n_idtx == k0; k++) @(posedge clk);
    rd(`LSP_OFS_STATUS, st);
    if (ok) begin
      `CHK_EQ(n_set, n0 + 1)
      `CHK_EQ(t_set, t_idrx + 1)
      `CHK_EQ(id_dst, nw)
      // The tick runs free, so the first tick of a wait may come at once
      `CHK_EQ(t_idtx - t_set > (int'(nwait) - 1) * 3125, 1'b1)
      `CHK_EQ(t_pr > t_set && t_idtx > t_pr, 1'b1)
      `CHK_EQ(st[10:8], 3'b001)
    end else begin
      `CHK_EQ(n_set, n0)
      `CHK_EQ(st[10:8], 3'b010)
    end
    $display("set address run done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dev_new = 8'h30;
    reply_dly = 16'ha;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rdat);
      `CHK_EQ(rdat, rows[i].e)
    end
    $display("register table done");
    walk_chk(8'h25, 8'hba, 80);
    walk_chk(8'h25, 8'h00, 250);
    gap_chk(1, 0);
    gap_chk(1, 1);
    wr(`LSP_OFS_TOK_HOLD, 32'h0);
    wr(`LSP_OFS_NODE_CNT, 32'h0);
    // Two ticks: a 3000-cycle reply always lands, a 7000-cycle one never
    wr(`LSP_OFS_RESP_WAIT, 32'h2);
    sa_run(8'h20, 8'h30, 32'h2, 16'ha, 1'b1);
    sa_run(8'h30, 8'h20, 32'h0, 16'd3000, 1'b1);
    sa_run(8'h20, 8'h40, 32'h0, 16'd7000, 1'b0);
    // Mid-run reset brings outputs and settings back to reset values
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    `CHK_EQ({probe_tx_q, query_tx_q, set_addr_tx_q, ident_tx_q, frame_dst_q}, 12'h000)
    rd(`LSP_OFS_SKIP_LEN, rdat);
    `CHK_EQ(rdat, 32'h0000_00ba)
    rd(`LSP_OFS_STATUS, rdat);
    `CHK_EQ(rdat, 32'h0000_0010)
    $display("reset test done");
    report_and_stop();
  end
endmodule
